// ### boot_refresh_pkg.sv
package boot_refresh_pkg;

    // Register map of the plain register port.
    localparam logic [3:0] ctrl_addr   = 4'h0;  // Refresh control register.
    localparam logic [3:0] status_addr = 4'h1;  // Refresh status register.
    localparam logic [3:0] ivl_addr    = 4'h2;  // Refresh interval register, in switching cycles.

    // Control register field positions.
    localparam int start_cnt_lsb  = 0;  // Startup pulse count, four bits.
    localparam int start_wide_bit = 4;  // Startup pulse width: 0 is 1/12, 1 is 1/6.
    localparam int drop_cnt8_bit  = 5;  // Dropped-phase burst: 0 is 4 pulses, 1 is 8.
    localparam int drop_wide_bit  = 6;  // Dropped-phase pulse width: 0 is 1/12, 1 is 1/6.

    // Reset values of the control fields.
    localparam logic [3:0] start_cnt_rst = 4'h8;  // Eight startup pulses.
    localparam logic [3:0] drop_cnt_4    = 4'h4;  // Default periodic burst.
    localparam logic [3:0] drop_cnt_8    = 4'h8;  // Optional periodic burst.
    localparam logic [15:0] ivl_rst      = 16'h0400;  // Default interval in switching cycles.

    // Pulse widths counted in twelfths of a switching cycle.
    localparam logic [3:0] width_narrow = 4'h1;  // One twelfth.
    localparam logic [3:0] width_wide   = 4'h2;  // One sixth.
    localparam logic [3:0] slots_per_cycle = 4'hc;  // Twelve slots per cycle.

    // Three-level phase output codes.
    typedef enum logic [1:0]
    {
        lvl_mid  = 2'h0,  // Both switches off.
        lvl_low  = 2'h1,  // Low-side on.
        lvl_high = 2'h2   // High-side on.
    } phase_level_e;

    // Sequencer states, Gray coded.
    typedef enum logic [1:0]
    {
        st_idle    = 2'b00,
        st_startup = 2'b01,
        st_wait    = 2'b11,
        st_burst   = 2'b10
    } seq_state_e;

    // Burst setting carried as one group.
    typedef struct packed
    {
        logic [3:0] count;  // Pulses per phase.
        logic [3:0] width;  // Pulse width in twelfths.
    } burst_cfg_s;

endpackage : boot_refresh_pkg

// ### boot_refresh_pulse_sequencer.sv
// Functional notes
// - Refresh only in buck with zero-current cutoff.
// - Startup: eight pulses, width one twelfth.
// - Startup width and count software programmable.
// - Refresh pulses keep normal interleave phase offset.
// - First drop starts interval counter; refresh dropped phases.
// - Periodic burst default four pulses, one twelfth.
// - Periodic burst selectable eight pulses, one sixth.
// - Pulse skipping refreshes all phases likewise.
// - Low level is refresh; middle both off.
// - Phase dropping only with three-level output.
`timescale 1ns/1ps
`default_nettype none

module boot_refresh_pulse_sequencer #(
    parameter int PHASES = 6  // Number of interleaved phases.
) (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic                slot_tick,        // One pulse per twelfth of a switching cycle.
    input  wire logic [PHASES-1:0]   phase_start,      // Per-phase interleaved cycle start pulses.
    input  wire logic                buck_mode,        // High in buck conversion.
    input  wire logic                zero_current_cutoff_mode, // High when diode emulation chosen.
    input  wire logic                tri_level_sel,    // High when three-level output selected.
    input  wire logic                startup_req,      // Pulse at device startup.
    input  wire logic                pulse_skip,       // High during pulse skipping.
    input  wire logic [PHASES-1:0]   drop_req,         // Per-phase drop request.
    input  wire logic [1:0]          pwm_in [PHASES],  // Normal three-level commands.
    input  wire logic [3:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    output logic [1:0]               pwm_out [PHASES], // Commands to the gate drivers.
    output logic                     refresh_busy      // High while a burst is active.
);

    // Pulse and width counters are four bits and the status word has room for a few phases only,
    // so larger phase counts are refused while the design is elaborated.
    if (PHASES < 1 || PHASES > 8)
    begin : g_bad_phases
        $error("PHASES must be 1 to 8.");
    end

    // Control and interval registers.
    logic [6:0]  ctrl_ff;   // Control fields.
    logic [15:0] ivl_ff;    // Interval length in switching cycles.

    // Refresh is allowed only in buck with cutoff switching.
    wire allow = buck_mode & zero_current_cutoff_mode;
    // Dropping counts only with three-level output.
    wire [PHASES-1:0] dropped = tri_level_sel ? drop_req : '0;
    wire periodic_need = (|dropped) | pulse_skip;
    // Periodic targets: all phases when skipping, else the dropped ones.
    wire [PHASES-1:0] per_mask = pulse_skip ? {PHASES{1'b1}} : dropped;

    // Burst settings decoded from control bits.
    boot_refresh_pkg::burst_cfg_s start_cfg;
    boot_refresh_pkg::burst_cfg_s per_cfg;
    assign start_cfg.count = ctrl_ff[boot_refresh_pkg::start_cnt_lsb +: 4];
    assign start_cfg.width = ctrl_ff[boot_refresh_pkg::start_wide_bit]
                           ? boot_refresh_pkg::width_wide : boot_refresh_pkg::width_narrow;
    assign per_cfg.count = ctrl_ff[boot_refresh_pkg::drop_cnt8_bit]
                         ? boot_refresh_pkg::drop_cnt_8 : boot_refresh_pkg::drop_cnt_4;
    assign per_cfg.width = ctrl_ff[boot_refresh_pkg::drop_wide_bit]
                         ? boot_refresh_pkg::width_wide : boot_refresh_pkg::width_narrow;

    // Sequencer state.
    boot_refresh_pkg::seq_state_e state_ff;
    boot_refresh_pkg::seq_state_e nxt_state;
    boot_refresh_pkg::burst_cfg_s cfg_ff;        // Burst setting in use.
    logic [PHASES-1:0]            target_ff;     // Phases being refreshed.
    logic [15:0]                  ivl_cnt_ff;    // Interval counter in cycles.
    logic [3:0]                   left_ff [PHASES]; // Pulses left per phase.
    logic [3:0]                   wcnt_ff [PHASES]; // Width slots left per phase.
    logic                         start_pend_ff; // Startup burst requested.

    // A cycle boundary is taken from the first phase start.
    wire cycle_tick = phase_start[0];
    wire [PHASES-1:0] done_vec;
    wire burst_done = &done_vec;

    genvar g;
    generate
        for (g = 0; g < PHASES; g++)
        begin : g_done
            assign done_vec[g] = ~target_ff[g] | (left_ff[g] == 4'h0 && wcnt_ff[g] == 4'h0);
        end
    endgenerate

    // Next-state logic of the sequencer.
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            boot_refresh_pkg::st_idle:
                if (allow && start_pend_ff)
                    nxt_state = boot_refresh_pkg::st_startup;
                else if (allow && periodic_need)
                    nxt_state = boot_refresh_pkg::st_wait;
            boot_refresh_pkg::st_startup:
                if (burst_done || !allow)
                    nxt_state = boot_refresh_pkg::st_idle;
            boot_refresh_pkg::st_wait:
                if (!allow || !periodic_need)
                    nxt_state = boot_refresh_pkg::st_idle;
                else if (cycle_tick && ivl_cnt_ff >= ivl_ff)
                    nxt_state = boot_refresh_pkg::st_burst;
            boot_refresh_pkg::st_burst:
                if (burst_done || !allow)
                    nxt_state = boot_refresh_pkg::st_wait;
        endcase
    end

    // State, configuration latch and interval counter.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_ff      <= boot_refresh_pkg::st_idle;
            cfg_ff        <= '0;
            target_ff     <= '0;
            ivl_cnt_ff    <= '0;
            start_pend_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            if (startup_req)
                start_pend_ff <= 1'b1;
            else if (nxt_state == boot_refresh_pkg::st_startup)
                start_pend_ff <= 1'b0;
            if (state_ff == boot_refresh_pkg::st_idle && nxt_state == boot_refresh_pkg::st_startup)
            begin
                cfg_ff    <= start_cfg;
                target_ff <= {PHASES{1'b1}};
            end
            else if (nxt_state == boot_refresh_pkg::st_burst && state_ff == boot_refresh_pkg::st_wait)
            begin
                cfg_ff    <= per_cfg;
                target_ff <= per_mask;
            end
            // Counter runs in whole cycles while waiting.
            if (state_ff != boot_refresh_pkg::st_wait)
                ivl_cnt_ff <= '0;
            else if (cycle_tick)
                ivl_cnt_ff <= (ivl_cnt_ff >= ivl_ff) ? 16'h0000 : ivl_cnt_ff + 16'h0001;
        end
    end

    wire bursting = (state_ff == boot_refresh_pkg::st_startup) || (state_ff == boot_refresh_pkg::st_burst);
    wire loading = (state_ff != nxt_state) && (nxt_state == boot_refresh_pkg::st_startup
                   || nxt_state == boot_refresh_pkg::st_burst);

    // Per-phase pulse generators, each launched by its own phase start.
    generate
        for (g = 0; g < PHASES; g++)
        begin : g_phase
            wire fire = bursting && target_ff[g] && phase_start[g] && left_ff[g] != 4'h0;
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    left_ff[g] <= 4'h0;
                    wcnt_ff[g] <= 4'h0;
                    pwm_out[g] <= boot_refresh_pkg::lvl_mid;
                end
                else
                begin
                    if (loading)
                        left_ff[g] <= (nxt_state == boot_refresh_pkg::st_startup) ? start_cfg.count : per_cfg.count;
                    else if (fire)
                        left_ff[g] <= left_ff[g] - 4'h1;
                    if (!bursting)
                        wcnt_ff[g] <= 4'h0;
                    else if (fire)
                        wcnt_ff[g] <= cfg_ff.width;
                    else if (slot_tick && wcnt_ff[g] != 4'h0)
                        wcnt_ff[g] <= wcnt_ff[g] - 4'h1;
                    // Low level forces the low-side switch on.
                    if (fire || (bursting && target_ff[g] && wcnt_ff[g] != 4'h0 && !(slot_tick && wcnt_ff[g] == 4'h1)))
                        pwm_out[g] <= boot_refresh_pkg::lvl_low;
                    else if (bursting && target_ff[g])
                        pwm_out[g] <= boot_refresh_pkg::lvl_mid;
                    else
                        pwm_out[g] <= pwm_in[g];
                end
            end
        end
    endgenerate

    // Register writes and read data.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ctrl_ff      <= {3'b000, boot_refresh_pkg::start_cnt_rst};
            ivl_ff       <= boot_refresh_pkg::ivl_rst;
            reg_rdata    <= 32'h0000_0000;
            refresh_busy <= 1'b0;
        end
        else
        begin
            refresh_busy <= bursting;
            if (reg_wr && reg_addr == boot_refresh_pkg::ctrl_addr)
                ctrl_ff <= reg_wdata[6:0];
            if (reg_wr && reg_addr == boot_refresh_pkg::ivl_addr)
                ivl_ff <= reg_wdata[15:0];
            if (!reg_rd)
                reg_rdata <= 32'h0000_0000;
            else if (reg_addr == boot_refresh_pkg::ctrl_addr)
                reg_rdata <= {25'h0, ctrl_ff};
            else if (reg_addr == boot_refresh_pkg::status_addr)
                reg_rdata <= {22'h0, target_ff[0], start_pend_ff, 6'h0, state_ff};
            else if (reg_addr == boot_refresh_pkg::ivl_addr)
                reg_rdata <= {16'h0, ivl_ff};
            else
                reg_rdata <= 32'h0000_0000;
        end
    end

    // Assertions.
    refresh_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !allow |-> ##1 !(state_ff == boot_refresh_pkg::st_burst && $past(state_ff) == boot_refresh_pkg::st_wait))
        else $error("Refresh started outside buck cutoff mode.");
    startup_default_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(sys_rst == 1'b0) |-> ctrl_ff[3:0] == 4'h8)
        else $error("Startup count default wrong.");
    // The default periodic setting must reach both the latched width and the pulse counter of phase 0.
    drop_width_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (loading && nxt_state == boot_refresh_pkg::st_burst && !ctrl_ff[boot_refresh_pkg::drop_wide_bit]
         && !ctrl_ff[boot_refresh_pkg::drop_cnt8_bit])
        |=> (cfg_ff.width == boot_refresh_pkg::width_narrow && left_ff[0] == boot_refresh_pkg::drop_cnt_4))
        else $error("Periodic default burst wrong.");
    two_level_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!tri_level_sel && !pulse_skip && state_ff != boot_refresh_pkg::st_burst) |=> state_ff != boot_refresh_pkg::st_burst)
        else $error("Drop honoured with two-level output.");
    pulse_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bursting && target_ff[0] && phase_start[0] && left_ff[0] != 4'h0) |=> pwm_out[0] == boot_refresh_pkg::lvl_low)
        else $error("Refresh pulse not low level.");
    // Outside a burst the normal command of phase 0 must reach the driver one cycle later, untouched.
    normal_pass_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !bursting |=> pwm_out[0] == $past(pwm_in[0]))
        else $error("Normal command not passed through.");
    busy_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bursting |=> refresh_busy)
        else $error("Busy flag low during a burst.");

endmodule : boot_refresh_pulse_sequencer

`default_nettype wire

// ### boot_refresh_pulse_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module boot_refresh_pulse_sequencer_tb;
    logic ref_clk, sys_rst, slot_tick, buck_mode, cutoff, tri_level_sel, startup_req, pulse_skip, reg_wr, reg_rd, clr;
    logic [5:0] phase_start, drop_req;
    logic [1:0] pwm_in [6], pwm_out [6];
    logic [3:0] reg_addr, slot_ff, cnt;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic refresh_busy, div_ff, wide;
    logic [7:0] low_cnt [6], low_width [6];
    int first_at [6], num_errors, total_checks, seed, ph;

    boot_refresh_pulse_sequencer #(.PHASES(6)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .slot_tick(slot_tick),
        .phase_start(phase_start), .buck_mode(buck_mode), .zero_current_cutoff_mode(cutoff),
        .tri_level_sel(tri_level_sel), .startup_req(startup_req), .pulse_skip(pulse_skip), .drop_req(drop_req),
        .pwm_in(pwm_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwm_out(pwm_out), .refresh_busy(refresh_busy));
    gate_driver_model #(.PHASES(6)) drv_u (.ref_clk(ref_clk), .clr(clr), .slot_tick(slot_tick), .pwm_cmd(pwm_out),
        .low_cnt(low_cnt), .low_width(low_width), .first_at(first_at));

    // Clock of 8 ns.
    always #4 ref_clk = ~ref_clk;

    // Oscillator stand-in: a slot every two cycles, phases two slots apart.
    always @(posedge ref_clk)
    begin
        div_ff <= !div_ff;
        slot_tick <= div_ff;
        if (div_ff)
            slot_ff <= (slot_ff == 4'hb) ? 4'h0 : slot_ff + 4'h1;
        for (int p = 0; p < 6; p++)
            phase_start[p] <= div_ff && (slot_ff == 4'(2 * p));
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // Register access; read data stand only in the cycle after the strobe.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd

    task automatic clear_stats;
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
    endtask : clear_stats

    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (refresh_busy !== lvl && n < lim)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        if (n == lim)
        begin
            num_errors++;
            $display("mismatch at %0t: busy wait ran out", $time);
        end
    endtask : wait_busy

    // One burst: expected count on masked phases, none elsewhere, width and spacing.
    task automatic wait_burst(input logic [5:0] mask, input logic [7:0] n, input logic [7:0] w);
        wait_busy(1'b1, 3000);
        wait_busy(1'b0, 6000);
        repeat (4) @(posedge ref_clk);
        #1;
        for (int p = 0; p < 6; p++)
        begin
            chk(low_cnt[p], mask[p] ? n : 8'h00);
            if (mask[p])
                chk(low_width[p], w);
            if (mask[p] && mask[0])
                chk(((first_at[p] - first_at[0]) % 24 + 24) % 24, p * 4);
        end
        @(posedge ref_clk);
    endtask : wait_burst

    // Nothing may be issued while refresh is not allowed, and normal commands pass straight through.
    task automatic expect_quiet;
        repeat (400) @(posedge ref_clk);
        #1 chk(refresh_busy, 1'b0);
        for (int p = 0; p < 6; p++)
            chk(low_cnt[p], 8'h00);
        @(posedge ref_clk);
        for (int p = 0; p < 6; p++)
            pwm_in[p] <= 2'($unsigned($random(seed)) % 3);
        repeat (2) @(posedge ref_clk);
        #1;
        for (int p = 0; p < 6; p++)
            chk(pwm_out[p], pwm_in[p]);
        @(posedge ref_clk);
        pwm_in <= '{default: boot_refresh_pkg::lvl_mid};
        clear_stats;
    endtask : expect_quiet

    initial
    begin
        seed = 32'hc446dd7e;
        {ref_clk, div_ff, slot_ff, slot_tick, phase_start, buck_mode, cutoff, startup_req, pulse_skip} = '0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, drop_req, clr} = '0;
        tri_level_sel = 1'b1;
        pwm_in = '{default: boot_refresh_pkg::lvl_mid};
        for (int run = 0; run < 2; run++)
        begin
            sys_rst <= 1'b1;
            repeat (3) @(posedge ref_clk);
            sys_rst <= 1'b0;
            {buck_mode, cutoff} <= 2'b00;
            rd(boot_refresh_pkg::ctrl_addr);
            chk(rd_val, 32'h8);
            rd(boot_refresh_pkg::ivl_addr);
            chk(rd_val, 32'h400);
            rd(boot_refresh_pkg::status_addr);
            chk(rd_val, 32'h100);
            rd(4'hf);
            chk(rd_val, 32'h0);
            cnt = run ? 4'h1 + 4'($unsigned($random(seed)) % 15) : 4'h8;
            wide = run ? 1'($random(seed)) : 1'b0;
            wr(boot_refresh_pkg::ctrl_addr, {27'h0, wide, cnt});
            wr(boot_refresh_pkg::ivl_addr, 32'h2);
            clear_stats;
            buck_mode <= 1'(run);
            cutoff <= 1'(!run);
            expect_quiet;
            buck_mode <= 1'b1;
            cutoff <= 1'b1;
            wait_burst(6'h3f, 8'(cnt), wide ? 8'h2 : 8'h1);
            $display("test startup %0d done", run);
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(boot_refresh_pkg::ctrl_addr, 32'(k << 5) | 32'h8);
            ph = $unsigned($random(seed)) % 6;
            clear_stats;
            drop_req <= 6'(1 << ph);
            wait_burst(6'(1 << ph), k[0] ? 8'h8 : 8'h4, k[1] ? 8'h2 : 8'h1);
            drop_req <= 6'h00;
            clear_stats;
            pulse_skip <= 1'b1;
            wait_burst(6'h3f, k[0] ? 8'h8 : 8'h4, k[1] ? 8'h2 : 8'h1);
            pulse_skip <= 1'b0;
            $display("test periodic %0d done", k);
        end
        // A startup request after the first burst must arm a fresh startup burst.
        clear_stats;
        startup_req <= 1'b1;
        @(posedge ref_clk);
        startup_req <= 1'b0;
        wait_burst(6'h3f, 8'h8, 8'h1);
        $display("test startup request done");
        tri_level_sel <= 1'b0;
        drop_req <= 6'h3f;
        clear_stats;
        expect_quiet;
        $display("test two level done");
        give_verdict;
    end

    // Watchdog sized well beyond the longest expected run.
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        give_verdict;
    end
endmodule : boot_refresh_pulse_sequencer_tb

`default_nettype wire

// ### gate_driver_model.sv
`timescale 1ns/1ps
`default_nettype none

// Tri-state half-bridge driver model that records low-side turn-on pulses per phase.
module gate_driver_model #(
    parameter int PHASES = 6  // Number of driven phases.
) (
    input  wire logic       ref_clk,
    input  wire logic       clr,                 // Clears all statistics.
    input  wire logic       slot_tick,           // Twelfth-cycle tick used to measure on-time.
    input  wire logic [1:0] pwm_cmd [PHASES],    // Three-level commands from the controller.
    output logic [7:0]      low_cnt [PHASES],    // Low-side turn-on count.
    output logic [7:0]      low_width [PHASES],  // Ticks seen during the last low pulse.
    output int              first_at [PHASES]    // Cycle of the first low pulse, or -1.
);
    int                cyc;       // Free-running cycle stamp.
    logic [PHASES-1:0] lo;        // Low-side switch commanded on.
    logic [PHASES-1:0] low_prev;  // Previous low state, for edge detection.
    logic [7:0]        run_w [PHASES];

    // Only the low level turns the low-side switch on; middle leaves both off.
    always_comb
    begin
        for (int p = 0; p < PHASES; p++)
            lo[p] = (pwm_cmd[p] === boot_refresh_pkg::lvl_low);
    end

    // The width is kept in ticks, so the measure does not depend on the slot rate.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        low_prev <= lo;
        for (int p = 0; p < PHASES; p++)
        begin
            if (clr)
            begin
                low_cnt[p] <= 8'h00;
                low_width[p] <= 8'h00;
                run_w[p] <= 8'h00;
                first_at[p] <= -1;
            end
            else if (lo[p])
            begin
                run_w[p] <= run_w[p] + 8'(slot_tick);
                if (!low_prev[p])
                    low_cnt[p] <= low_cnt[p] + 8'h01;
                if (!low_prev[p] && first_at[p] < 0)
                    first_at[p] <= cyc;
            end
            else if (low_prev[p])
            begin
                low_width[p] <= run_w[p];
                run_w[p] <= 8'h00;
            end
        end
    end
endmodule : gate_driver_model

`default_nettype wire
